/* hw/bmc_pkg.sv */
package bmc_pkg;
  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [7:0] BMC_CTRL_OFFSET  = 8'h00;
  localparam logic [7:0] BMC_STAT_OFFSET  = 8'h04;
  localparam logic [7:0] BMC_CTRL_RESET   = 8'h02;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int BMC_PROTO_LSB = 6;
  localparam int BMC_MUX_BIT   = 5;
  localparam int BMC_RSVD_BIT  = 4;
  localparam int BMC_LEN_LSB   = 0;
  localparam logic [7:0] BMC_CTRL_WMASK = 8'hef;

  // ---------------------------------------------------------------
  // protocol codes
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    BMC_NATIVE  = 2'h0,
    BMC_LEGACY8 = 2'h1,
    BMC_LATCH   = 2'h2,
    BMC_ACK     = 2'h3
  } bmc_proto_e;

  // native protocol bus state length in cycles
  localparam logic [3:0] BMC_NATIVE_LEN = 4'h1;
endpackage

/* hw/bmc_state_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module bmc_state_timer #(
  parameter int LEN_W = 4
) (
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire logic             run,
  input  wire logic [LEN_W-1:0] len,
  output var  logic             state_end
);
  logic [LEN_W-1:0] cnt_ff;
  logic [LEN_W-1:0] nxt_cnt;
  logic             end_ff;
  logic             nxt_end;

  // a zero-width counter cannot hold any state length
  if (LEN_W < 1) begin : g_len_w_check
    $error("bmc_state_timer: LEN_W must be positive");
  end

  // counts cycles within a state; a zero length is treated like one
  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_end = 1'b0;
    if (!run) begin
      nxt_cnt = '0;
    end else if (cnt_ff + LEN_W'(1) >= len) begin
      nxt_cnt = '0;
      nxt_end = 1'b1;
    end else begin
      nxt_cnt = cnt_ff + LEN_W'(1);
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_ff <= '0;
      end_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      end_ff <= nxt_end;
    end
  end

  assign state_end = end_ff;
endmodule
`default_nettype wire

/* hw/bmc_top.sv */
// Behaviour
// - bit 5 set multiplexes address onto data pins, clear keeps them separate
// - bit 4 reserved, reads zero; all other bits read and write
// - each bus state lasts the four-bit length in cycles; zero is invalid
// - in native protocol the length field does not affect timing
//
// Design decisions made here: the register addresses and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module bmc_top (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire logic        bus_run,
  output var  logic [1:0]  bus_protocol,
  output var  logic        addr_data_multiplex,
  output var  logic        bus_state_step,
  output var  logic        len_invalid
);
  import bmc_pkg::*;

  // ---------------------------------------------------------------
  // apb slave
  // ---------------------------------------------------------------
  logic [7:0]  ctrl_ff;
  logic [7:0]  nxt_ctrl;
  logic [31:0] prdata_ff;
  logic [31:0] nxt_prdata;
  logic        pready_ff;
  logic        nxt_pready;
  logic        pslverr_ff;
  logic        nxt_pslverr;
  logic        step_ff;
  logic        timer_end;
  logic [3:0]  eff_len;
  logic        setup;

  // one wait state: pready rises in the second access cycle
  assign setup = psel && penable && !pready_ff;

  always_comb begin
    nxt_ctrl    = ctrl_ff;
    nxt_prdata  = prdata_ff;
    nxt_pready  = 1'b0;
    nxt_pslverr = 1'b0;
    if (setup) begin
      nxt_pready = 1'b1;
      unique case (paddr)
        BMC_CTRL_OFFSET: begin
          if (pwrite) begin
            nxt_ctrl = pwdata[7:0] & BMC_CTRL_WMASK;
          end else begin
            nxt_prdata = {24'h0, ctrl_ff & BMC_CTRL_WMASK};
          end
        end
        BMC_STAT_OFFSET: begin
          if (!pwrite) begin
            nxt_prdata = {28'h0, len_invalid, bus_state_step, addr_data_multiplex, 1'b0};
          end
        end
        default: begin
          // unmapped addresses answer with an error and no side effect
          nxt_pslverr = 1'b1;
          nxt_prdata  = 32'h0;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_ff    <= BMC_CTRL_RESET;
      prdata_ff  <= 32'h0;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      ctrl_ff    <= nxt_ctrl;
      prdata_ff  <= nxt_prdata;
      pready_ff  <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
    end
  end

  assign prdata  = prdata_ff;
  assign pready  = pready_ff;
  assign pslverr = pslverr_ff;

  // ---------------------------------------------------------------
  // bus mode outputs
  // ---------------------------------------------------------------
  logic [1:0] proto_ff;
  logic       mux_ff;
  logic       inval_ff;
  logic       nxt_inval;

  // native mode ignores the length field; a zero length is flagged, not obeyed
  always_comb begin
    eff_len = ctrl_ff[BMC_LEN_LSB +: 4];
    if (bmc_proto_e'(ctrl_ff[BMC_PROTO_LSB +: 2]) == BMC_NATIVE) begin
      eff_len = BMC_NATIVE_LEN;
    end
    nxt_inval = (ctrl_ff[BMC_LEN_LSB +: 4] == 4'h0);
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      proto_ff <= 2'h0;
      mux_ff   <= 1'b0;
      inval_ff <= 1'b0;
      step_ff  <= 1'b0;
    end else begin
      proto_ff <= ctrl_ff[BMC_PROTO_LSB +: 2];
      mux_ff   <= ctrl_ff[BMC_MUX_BIT];
      inval_ff <= nxt_inval;
      step_ff  <= timer_end;
    end
  end

  // timer marks the end of each bus state while a cycle runs
  bmc_state_timer #(
    .LEN_W (4)
  ) u_timer (
    .clk       (clk),
    .rstn      (rstn),
    .run       (bus_run),
    .len       (eff_len),
    .state_end (timer_end)
  );

  assign bus_protocol        = proto_ff;
  assign addr_data_multiplex = mux_ff;
  assign bus_state_step      = step_ff;
  assign len_invalid         = inval_ff;
endmodule
`default_nettype wire

/* test/bmc_far_dev.sv */
`timescale 1ns/1ps
`default_nettype none
// far side: measures cycles between bus state ends
module bmc_far_dev (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       bus_state_step,
  output var  logic [7:0] gap
);
  logic [7:0] cnt;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt <= 8'h00;
      gap <= 8'h00;
    end else if (bus_state_step) begin
      gap <= cnt + 8'h01;
      cnt <= 8'h00;
    end else begin
      cnt <= cnt + 8'h01;
    end
  end
endmodule
`default_nettype wire

/* test/bmc_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module bmc_monitor (
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        bus_run,
  input wire logic [1:0]  bus_protocol,
  input wire logic        addr_data_multiplex,
  input wire logic        bus_state_step,
  input wire logic        len_invalid
);
  // ------------------------------------------------
  // checks on register access and bus timing outputs
  // ------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  rdy_answer_a: assert property (psel && penable && !pready |=> pready) else $error("late ready");
  rdy_pulse_a: assert property (pready |=> !pready) else $error("ready too long");
  err_ready_a: assert property (pslverr |-> pready) else $error("stray error");
  rsvd_zero_a: assert property (pready && !pwrite && paddr == 8'h00 |-> !prdata[4]) else $error("bit4 set");
  // native timing ignores the length, so steps come each cycle
  native_step_a: assert property (bus_protocol == 2'h0 && $past(bus_protocol, 2) == 2'h0 && $past(bus_run)
    && $past(bus_run, 2) && $past(bus_run, 3) |-> bus_state_step) else $error("native step missing");
  idle_step_a: assert property (!$past(bus_run) && !$past(bus_run, 2) |-> !bus_state_step) else $error("idle step");
  cfg_change_a: assert property ($changed({bus_protocol, addr_data_multiplex}) |-> $past(pready) || $past(pready, 2))
    else $error("config moved alone");
  len_flag_a: assert property ($changed(len_invalid) |-> $past(pready) || $past(pready, 2)) else $error("flag moved");
endmodule
bind bmc_top bmc_monitor i_bmc_monitor (.*);
`default_nettype wire

/* test/tb_bmc_top.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin num_errors++; $display("MISMATCH %0t %h %h", $time, a, e); end end
module tb_bmc_top;
  import bmc_pkg::*;
  logic        clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, bus_run = 0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  logic [1:0]  bus_protocol;
  logic        addr_data_multiplex, bus_state_step, len_invalid, pready, pslverr, rerr;
  logic [7:0]  gap;
  logic [7:0]  cfg [4] = '{8'h41, 8'h42, 8'h4f, 8'h05};
  logic [7:0]  gexp [4] = '{8'h01, 8'h02, 8'h0f, 8'h01};
  int          num_errors = 0, n_compared = 0;
  bmc_top i_bmc_top (.*);
  bmc_far_dev i_bmc_far_dev (.*);
  initial begin
    forever #2 clk = ~clk;
  end
  // ------------------------------------------------
  // apb master: waits on pready, no assumed latency
  // ------------------------------------------------
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic results;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // watchdog: the whole run needs well under 5000 cycles
  initial begin
    #20000;
    num_errors++;
    results();
  end
  initial begin
    repeat (3) @(posedge clk);
    rstn <= 1;
    xfer(0, BMC_CTRL_OFFSET, 0); `CHK(rdat, {24'h0, BMC_CTRL_RESET})
    $display("test reset done");
    // every protocol code; length 3 keeps latch-strobe and wait use legal
    for (int i = 0; i < 4; i++) begin
      xfer(1, BMC_CTRL_OFFSET, {24'h0, i[1:0], i[0], 5'h13});
      xfer(0, BMC_CTRL_OFFSET, 0); `CHK(rdat, {24'h0, i[1:0], i[0], 5'h03})
      `CHK(bus_protocol, i[1:0])
      `CHK(addr_data_multiplex, i[0])
    end
    xfer(0, 8'h08, 0); `CHK(rerr, 1'b1)
    xfer(1, BMC_CTRL_OFFSET, 0);
    xfer(0, BMC_STAT_OFFSET, 0); `CHK(rdat[3], 1'b1)
    $display("test config done");
    // legacy lengths 1, 2, 15, then native with length 5
    for (int k = 0; k < 4; k++) begin
      xfer(1, BMC_CTRL_OFFSET, {24'h0, cfg[k]});
      bus_run <= 1;
      repeat (40) @(posedge clk);
      `CHK(gap, gexp[k])
      bus_run <= 0;
    end
    $display("test timing done");
    results();
  end
endmodule
`default_nettype wire
